// ---- i2c_eeprom_device.sv ----
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_device
  import i2c_eeprom_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        chip_strap_bit0_in,
  input  wire logic        chip_strap_bit1_in,
  input  wire logic        chip_strap_bit2_in,
  input  wire logic        write_protect_input_in,
  output logic             write_busy_out,
  output logic             selected_out,
  output logic [15:0]      mem_addr_out,
  i2c_link_if.device       link
);

  typedef struct packed {
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_s3;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_s3;
    logic [2:0]  strap_s1;
    logic [2:0]  strap;
    logic        wp_s1;
    logic        wp;
    dev_state_t  st;
    logic [3:0]  bit_cnt;
    logic        ack_phase;
    logic [7:0]  sh;
    logic [15:0] addr;
    logic [15:0] waddr;
    logic [7:0]  wdata;
    logic        wpend;
    logic [12:0] busy_cnt;
    logic        sda_oe;
    logic        busy;
    logic        selected;
  } dev_q_t;

  dev_q_t     q;
  dev_q_t     d;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] rd_byte;
  logic [7:0] next_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sel_match;
  logic       commit;

  // Pins float low by the board's pull-downs, so an open strap or write
  // protect simply arrives here as zero.
  assign scl_rise  = q.scl_s2 && !q.scl_s3;
  assign scl_fall  = !q.scl_s2 && q.scl_s3;
  assign start_det = q.sda_s3 && !q.sda_s2 && q.scl_s2 && q.scl_s3;
  assign stop_det  = !q.sda_s3 && q.sda_s2 && q.scl_s2 && q.scl_s3;
  assign sel_match = (q.sh[7:4] == DEV_TYPE) &&
                     (q.sh[3:1] == q.strap);
  assign rd_byte   = mem[q.addr[MEM_AW-1:0]];
  assign next_byte = mem[13'(q.addr[MEM_AW-1:0] + 13'h1)];
  assign commit    = (q.st == D_BUSY) && (q.busy_cnt == 13'h0);

  always_comb begin
    d          = q;
    d.scl_s1   = link.scl;
    d.scl_s2   = q.scl_s1;
    d.scl_s3   = q.scl_s2;
    d.sda_s1   = link.sda;
    d.sda_s2   = q.sda_s1;
    d.sda_s3   = q.sda_s2;
    d.strap_s1 = {chip_strap_bit2_in, chip_strap_bit1_in,
                  chip_strap_bit0_in};
    d.strap    = q.strap_s1;
    d.wp_s1    = write_protect_input_in;
    d.wp       = q.wp_s1;
    if (q.st == D_BUSY) begin
      d.sda_oe = 1'b0;
      if (q.busy_cnt == 13'h0) begin
        d.st    = D_IDLE;
        d.wpend = 1'b0;
      end else begin
        d.busy_cnt = q.busy_cnt - 13'h1;
      end
    end else if (start_det) begin
      d.st        = D_SEL;
      d.bit_cnt   = 4'h0;
      d.ack_phase = 1'b0;
      d.sda_oe    = 1'b0;
      d.wpend     = 1'b0;
    end else if (stop_det) begin
      d.sda_oe    = 1'b0;
      d.ack_phase = 1'b0;
      d.st        = D_IDLE;
      // Only a stop in the slot right after a data acknowledge programs.
      if (q.st == D_WDATA && q.wpend && !q.ack_phase &&
          q.bit_cnt <= FRAME_SLOT_MAX) begin
        d.st       = D_BUSY;
        d.busy_cnt = WRITE_CNT_INIT;
      end
    end else if (q.st != D_IDLE && scl_rise) begin
      if (q.ack_phase) begin
        if (q.st == D_RDATA && q.sda_s2) begin
          d.st = D_IDLE;
        end
      end else begin
        d.bit_cnt = q.bit_cnt + 4'h1;
        if (q.st != D_RDATA) begin
          d.sh = {q.sh[6:0], q.sda_s2};
        end
      end
    end else if (q.st != D_IDLE && scl_fall) begin
      if (q.ack_phase) begin
        d.ack_phase = 1'b0;
        d.sda_oe    = 1'b0;
        d.bit_cnt   = 4'h0;
        if (q.st == D_RDATA) begin
          // The master acknowledged, so the next byte goes out at once.
          d.sh     = q.sh;
          d.sda_oe = !q.sh[7];
        end
      end else if (q.bit_cnt == BITS_PER_BYTE) begin
        d.ack_phase = 1'b1;
        d.sda_oe    = 1'b1;
        unique case (q.st)
          D_SEL: begin
            if (!sel_match) begin
              d.st        = D_IDLE;
              d.ack_phase = 1'b0;
              d.sda_oe    = 1'b0;
            end else if (q.sh[0]) begin
              d.st = D_RDATA;
              d.sh = rd_byte;
            end else begin
              d.st = D_AHI;
            end
          end
          D_AHI: begin
            d.addr[15:8] = q.sh;
            d.st         = D_ALO;
          end
          D_ALO: begin
            d.addr[7:0] = q.sh;
            d.st        = D_WDATA;
          end
          D_WDATA: begin
            if (q.wp) begin
              d.sda_oe = 1'b0;
            end else begin
              d.wdata = q.sh;
              d.waddr = q.addr;
              d.wpend = 1'b1;
              d.addr  = q.addr + 16'h1;
            end
          end
          D_RDATA: begin
            d.sda_oe = 1'b0;
            d.addr   = q.addr + 16'h1;
            d.sh     = next_byte;
          end
          default: begin
            d.st = D_IDLE;
          end
        endcase
      end else if (q.st == D_RDATA) begin
        d.sda_oe = !q.sh[3'h7 - q.bit_cnt[2:0]];
      end
    end
    d.busy     = (d.st == D_BUSY);
    d.selected = (d.st != D_IDLE) && (d.st != D_SEL) && (d.st != D_BUSY);
  end

  // Reset is the power-on reset: while it is low every bit rests and the
  // bus is ignored, both on the way up and on the way down.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q        <= '0;
      q.scl_s1 <= 1'b1;
      q.scl_s2 <= 1'b1;
      q.scl_s3 <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
      q.sda_s3 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // The array has no reset; its contents are the non-volatile store.
  always_ff @(posedge clk_in) begin
    if (commit && !q.wp) begin
      mem[q.waddr[MEM_AW-1:0]] <= q.wdata;
    end
  end

  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe  = q.sda_oe;
  assign write_busy_out   = q.busy;
  assign selected_out     = q.selected;
  assign mem_addr_out     = q.addr;

endmodule
`default_nettype wire

// ---- i2c_eeprom_pkg.sv ----
package i2c_eeprom_pkg;

  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          MEM_DEPTH      = 8192;
  localparam int          MEM_AW         = 13;
  localparam logic [3:0]  DEV_TYPE       = 4'ha;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0]  FRAME_SLOT_MAX = 4'h1;
  // Internal write time; least time, so the count rounds up.
  localparam int          WRITE_TIME_NS  = 5000;
  localparam int          WRITE_CYC      =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] WRITE_CNT_INIT = 13'(WRITE_CYC - 1);
  // The master spends four quarters on every SCL slot.
  localparam int          SCL_QUARTER_NS = 16;
  localparam int          SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  DIV_LAST       = 4'(SCL_QUARTER_CYC - 1);
  localparam logic [2:0]  WR_STOP_STEP   = 3'h5;
  localparam logic [2:0]  RD_STOP_STEP   = 3'h7;

  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_SEL   = 3'b001,
    D_AHI   = 3'b010,
    D_ALO   = 3'b011,
    D_WDATA = 3'b100,
    D_RDATA = 3'b101,
    D_BUSY  = 3'b110
  } dev_state_t;

  typedef enum logic [1:0] {
    K_START = 2'b00,
    K_TX    = 2'b01,
    K_RX    = 2'b10,
    K_STOP  = 2'b11
  } slot_kind_t;

endpackage

// ---- i2c_eeprom_slave_select_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_eeprom_slave_select_test
  import i2c_eeprom_pkg::*;
;
  logic        clk_in       = 1'b0;
  logic        rst_b_in     = 1'b0;
  logic        cmd_valid_in = 1'b0;
  logic        cmd_read_in  = 1'b0;
  logic [2:0]  cmd_strap_in = 3'h6;
  logic [15:0] cmd_addr_in  = 16'h0;
  logic [7:0]  cmd_wdata_in = 8'h0;
  logic [2:0]  dev_strap    = 3'h6;
  logic        wp           = 1'b0;
  logic        busy_out;
  logic        done_out;
  logic        nack_out;
  logic [7:0]  rdata_out;
  logic        write_busy_out;
  logic        selected_out;
  logic [15:0] mem_addr_out;
  int          errors       = 0;
  int          n_compared   = 0;
  int          cycles       = 0;

  i2c_link_if i2c_link_if_i ();
  i2c_master_end i2c_master_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .cmd_valid_in(cmd_valid_in), .cmd_read_in(cmd_read_in),
    .cmd_strap_in(cmd_strap_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .busy_out(busy_out), .done_out(done_out),
    .nack_out(nack_out), .rdata_out(rdata_out), .link(i2c_link_if_i));
  i2c_eeprom_device i2c_eeprom_device_i (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .chip_strap_bit0_in(dev_strap[0]),
    .chip_strap_bit1_in(dev_strap[1]), .chip_strap_bit2_in(dev_strap[2]),
    .write_protect_input_in(wp), .write_busy_out(write_busy_out),
    .selected_out(selected_out), .mem_addr_out(mem_addr_out),
    .link(i2c_link_if_i));
  i2c_link_checker i2c_link_checker_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
    .sda_dev_out(i2c_link_if_i.sda_dev_out),
    .sda_dev_oe(i2c_link_if_i.sda_dev_oe),
    .write_busy_out(write_busy_out));

  always #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;

  task automatic end_of_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs roughly 8700 cycles; this ceiling cuts a hang.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("unexpected timeout: expected finish, seen hang");
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic rd, input logic [2:0] strap,
                     input logic [15:0] addr, input logic [7:0] wd);
    int n;
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_read_in  <= rd;
    cmd_strap_in <= strap;
    cmd_addr_in  <= addr;
    cmd_wdata_in <= wd;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    @(posedge clk_in);
    check("busy", 16'h1, {15'h0, busy_out});
    n = 0;
    while (done_out !== 1'b1 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    check("done", 16'h1, {15'h0, done_out});
    check("idle", 16'h0, {15'h0, busy_out});
  endtask

  // Write at a high alias, hit the busy window, then read it back low.
  task automatic t_write_read;
    int n;
    run(1'b0, 3'h6, 16'he345, 8'h5a);
    check("write nack", 16'h0, {15'h0, nack_out});
    check("write addr", 16'he346, mem_addr_out);
    repeat (8) @(posedge clk_in);
    check("write busy", 16'h1, {15'h0, write_busy_out});
    run(1'b1, 3'h6, 16'h0345, 8'h0);
    check("nack while busy", 16'h1, {15'h0, nack_out});
    n = 0;
    while (write_busy_out !== 1'b0 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    run(1'b1, 3'h6, 16'h0345, 8'h0);
    check("readback", 16'h005a, {8'h0, rdata_out});
    check("readback nack", 16'h0, {15'h0, nack_out});
    check("read addr", 16'h0346, mem_addr_out);
  endtask

  // Every chip-enable code; only the strapped one is answered.
  task automatic t_straps;
    for (int s = 0; s < 8; s++) begin
      run(1'b1, 3'(s), 16'h0345, 8'h0);
      check("strap nack", {15'h0, s != 6}, {15'h0, nack_out});
    end
    // Open straps read as zero, so the all-zero code must be answered.
    dev_strap <= 3'h0;
    run(1'b1, 3'h0, 16'h0345, 8'h0);
    check("zero strap nack", 16'h0, {15'h0, nack_out});
    check("zero strap data", 16'h005a, {8'h0, rdata_out});
    dev_strap <= 3'h6;
  endtask

  // Protected: select and address taken, data refused, array kept.
  task automatic t_protect;
    wp <= 1'b1;
    run(1'b1, 3'h6, 16'h0345, 8'h0);
    check("wp read nack", 16'h0, {15'h0, nack_out});
    run(1'b0, 3'h6, 16'h0345, 8'ha5);
    check("wp data nack", 16'h1, {15'h0, nack_out});
    repeat (8) @(posedge clk_in);
    check("wp busy", 16'h0, {15'h0, write_busy_out});
    wp <= 1'b0;
    run(1'b1, 3'h6, 16'h0345, 8'h0);
    check("wp readback", 16'h005a, {8'h0, rdata_out});
  endtask

  // Reset in mid-frame silences both ends; the bus works again after.
  task automatic t_reset;
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_read_in  <= 1'b1;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    // By now the select byte is acknowledged and an address byte runs.
    repeat (300) @(posedge clk_in);
    check("frame selected", 16'h1, {15'h0, selected_out});
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("reset selected", 16'h0, {15'h0, selected_out});
    check("reset oe", 16'h0, {15'h0, i2c_link_if_i.sda_dev_oe});
    rst_b_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    run(1'b1, 3'h6, 16'h0345, 8'h0);
    check("after reset", 16'h005a, {8'h0, rdata_out});
  endtask

  initial begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    t_write_read();
    t_straps();
    t_protect();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- i2c_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_link_checker
  import i2c_eeprom_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic write_busy_out
);
  logic [12:0] busy_cnt_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Length of the running internal write, judged when it ends.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_cnt_q <= 13'h0;
    end else begin
      busy_cnt_q <= write_busy_out ? busy_cnt_q + 13'h1 : 13'h0;
    end
  end

  property p_low_only;
    sda_dev_oe |-> !sda_dev_out && !sda;
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("device drives the data line high");
  property p_busy_quiet;
    write_busy_out |-> !sda_dev_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device drives the data line during a write");
  property p_reset_quiet;
    $rose(rst_b_in) |-> !sda_dev_oe && !write_busy_out;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("device active right after reset");
  property p_scl_low_change;
    $changed(sda_dev_oe) |-> !scl;
  endproperty
  a_scl_low_change: assert property (p_scl_low_change)
    else $error("device data changed while the clock was high");
  property p_oe_hold;
    $rose(sda_dev_oe) |-> sda_dev_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("device bit shorter than half a slot");
  property p_oe_release;
    $rose(sda_dev_oe) |-> ##[1:200] !sda_dev_oe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("device never released the data line");
  property p_busy_len;
    $fell(write_busy_out) |-> busy_cnt_q == 13'(WRITE_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("internal write has the wrong length");
  property p_busy_cause;
    $rose(write_busy_out) |-> scl && sda;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("internal write began without a stop");
endmodule
`default_nettype wire

// ---- i2c_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic scl;
  logic sda_mst_out;
  logic sda_mst_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;

  // Wired-AND bus with pull-up: any enabled low driver wins.
  assign sda = !((sda_mst_oe && !sda_mst_out) || (sda_dev_oe && !sda_dev_out));

  modport master (output scl, output sda_mst_out, output sda_mst_oe,
                  input sda);
  modport device (input scl, output sda_dev_out, output sda_dev_oe,
                  input sda);
endinterface
`default_nettype wire

// ---- i2c_master_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_master_end
  import i2c_eeprom_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        cmd_valid_in,
  input  wire logic        cmd_read_in,
  input  wire logic [2:0]  cmd_strap_in,
  input  wire logic [15:0] cmd_addr_in,
  input  wire logic [7:0]  cmd_wdata_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             nack_out,
  output logic [7:0]       rdata_out,
  i2c_link_if.master       link
);

  typedef struct packed {
    logic        sda_s1;
    logic        sda_s2;
    logic        busy;
    logic        done;
    slot_kind_t  kind;
    logic [1:0]  qtr;
    logic [3:0]  div;
    logic [3:0]  bit_idx;
    logic [2:0]  step;
    logic [7:0]  sh;
    logic        rd;
    logic [2:0]  strap;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        nack;
    logic        scl;
    logic        sda_oe;
  } mst_state_t;

  mst_state_t q;
  mst_state_t d;

  function automatic slot_kind_t step_kind(input logic rd,
                                           input logic [2:0] s);
    slot_kind_t k;
    k = K_TX;
    if (s == 3'h0 || (rd && s == 3'h4)) begin
      k = K_START;
    end else if (s == (rd ? RD_STOP_STEP : WR_STOP_STEP)) begin
      k = K_STOP;
    end else if (rd && s == 3'h6) begin
      k = K_RX;
    end
    return k;
  endfunction

  function automatic logic [7:0] step_byte(input mst_state_t m,
                                           input logic [2:0] s);
    logic [7:0] b;
    b = {DEV_TYPE, m.strap, 1'b0};
    unique case (s)
      3'h2:    b = m.addr[15:8];
      3'h3:    b = m.addr[7:0];
      3'h4:    b = m.wdata;
      3'h5:    b = {DEV_TYPE, m.strap, 1'b1};
      default: b = {DEV_TYPE, m.strap, 1'b0};
    endcase
    return b;
  endfunction

  always_comb begin
    d        = q;
    d.sda_s1 = link.sda;
    d.sda_s2 = q.sda_s1;
    d.done   = 1'b0;
    if (!q.busy) begin
      if (cmd_valid_in) begin
        d.busy    = 1'b1;
        d.rd      = cmd_read_in;
        d.strap   = cmd_strap_in;
        d.addr    = cmd_addr_in;
        d.wdata   = cmd_wdata_in;
        d.nack    = 1'b0;
        d.step    = 3'h0;
        d.kind    = K_START;
        d.qtr     = 2'h0;
        d.div     = 4'h0;
        d.bit_idx = 4'h0;
      end
    end else if (q.div != DIV_LAST) begin
      d.div = q.div + 4'h1;
    end else begin
      d.div = 4'h0;
      d.qtr = q.qtr + 2'h1;
      unique case (q.kind)
        K_START: begin
          unique case (q.qtr)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl    = 1'b1;
            2'h2: d.sda_oe = 1'b1;
            2'h3: d.scl    = 1'b0;
          endcase
        end
        K_STOP: begin
          unique case (q.qtr)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl    = 1'b1;
            2'h2: d.sda_oe = 1'b0;
            2'h3: begin
              d.busy = 1'b0;
              d.done = 1'b1;
            end
          endcase
        end
        default: begin
          unique case (q.qtr)
            2'h0: begin
              if (q.bit_idx == BITS_PER_BYTE) begin
                // A single byte is read, so the master answers it with
                // not_acknowledge before its stop.
                d.sda_oe = 1'b0;
              end else begin
                d.sda_oe = (q.kind == K_TX) ? !q.sh[7] : 1'b0;
              end
            end
            2'h1: d.scl = 1'b1;
            2'h2: begin
              if (q.kind == K_TX && q.bit_idx == BITS_PER_BYTE) begin
                d.nack = q.nack | q.sda_s2;
              end else if (q.kind == K_RX && q.bit_idx != BITS_PER_BYTE) begin
                d.sh = {q.sh[6:0], q.sda_s2};
              end
            end
            2'h3: begin
              d.scl     = 1'b0;
              d.bit_idx = q.bit_idx + 4'h1;
              if (q.kind == K_TX && q.bit_idx != BITS_PER_BYTE) begin
                d.sh = {q.sh[6:0], 1'b0};
              end
              if (q.kind == K_RX && q.bit_idx == BITS_PER_BYTE) begin
                d.rdata = q.sh;
              end
            end
          endcase
        end
      endcase
      if (q.qtr == 2'h3 && (q.kind != K_STOP) &&
          (q.kind == K_START || q.bit_idx == BITS_PER_BYTE)) begin
        d.step = q.step + 3'h1;
        if (q.kind == K_TX && (q.nack | q.sda_s2 | d.nack)) begin
          // A refused byte ends the frame at once.
          d.step = q.rd ? RD_STOP_STEP : WR_STOP_STEP;
        end
        d.kind    = step_kind(q.rd, d.step);
        d.sh      = step_byte(q, d.step);
        d.bit_idx = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q        <= '0;
      q.scl    <= 1'b1;
      q.sda_s1 <= 1'b1;
      q.sda_s2 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.scl         = q.scl;
  assign link.sda_mst_out = 1'b0;
  assign link.sda_mst_oe  = q.sda_oe;
  assign busy_out         = q.busy;
  assign done_out         = q.done;
  assign nack_out         = q.nack;
  assign rdata_out        = q.rdata;

endmodule
`default_nettype wire
